/* File: ssie_defines.vh */
// Constants for the safety switch input evaluator
// Overview of operation
// [R1] The timed two-closer/one-opener group must reach its complete state within 3 s of any change, else fault and output 0.
// [R2] The untimed two-closer/one-opener group gives 1 only when inputs one and two are 1 and input three is 0.
// [R3] The untimed three-opener group gives 1 only when all three inputs are 1.
// [R4] The timed three-opener group must see the other two inputs follow within 3 s of a change, else fault and output 0.
// [R5] The two-hand closer/opener group must reach the actuated state within 0.5 s of the first contact leaving rest.
// [R6] The two-hand closer/opener group gives 1 only when actuated, with no timing on release and no interference check.
// [R7] The two-hand synchronism timer starts when any contact leaves rest, an OR over plain and inverted inputs.
// [R8] The two-hand closer pair must see the second closer reach 0 within 0.5 s of the first, else output stays 0.
// [R9] The two-hand closer pair gives 1 only with both inputs at 0, with no timing on release.
// [R10] The two-position selector drives output one for 1/0 and output two for 0/1, and nothing otherwise.
// [R11] The three-position selector drives output one only for inputs 1/0/0.
// [R12] Outputs two and three follow inputs two and three alone, and any multiple selection gives all zeros.
// [R13] A timing fault is held with output 0 until every input of the group is back at rest.
// [R14] The windows are counted in prescaler ticks from the system clock, with lengths set by parameters.
`ifndef SSIE_DEFINES_VH
`define SSIE_DEFINES_VH

`define SSIE_CLK_MHZ 200
`define SSIE_TICK_US 1000
`define SSIE_PRESCALE_CYC (`SSIE_CLK_MHZ * `SSIE_TICK_US)
`define SSIE_DISC_MS 3000
`define SSIE_SYNC_MS 500
`define SSIE_DISC_TICKS (`SSIE_DISC_MS * 1000 / `SSIE_TICK_US)
`define SSIE_SYNC_TICKS (`SSIE_SYNC_MS * 1000 / `SSIE_TICK_US)
`define SSIE_CNT_W 12
`define SSIE_PRE_W 18
`define SSIE_NUM_MON 4
`define SSIE_NUM_DISC 2

`define SSIE_ST_IDLE 3'h0
`define SSIE_ST_WAIT 3'h1
`define SSIE_ST_ACT 3'h2
`define SSIE_ST_FAULT 3'h3
`define SSIE_ST_LOCK 3'h4

`endif

/* File: ssie_top.v */
// Safety switch input evaluator: static, timed, two-hand and selector decodes
`timescale 1ns/100ps
`include "ssie_defines.vh"
module ssie_top #(
  parameter PRESCALE = `SSIE_PRESCALE_CYC,
  parameter [`SSIE_CNT_W-1:0] DISC_TICKS = `SSIE_DISC_TICKS,
  parameter [`SSIE_CNT_W-1:0] SYNC_TICKS = `SSIE_SYNC_TICKS
) (
  input wire clk_i,
  input wire srst_i,
  input wire [2:0] three_contact_in_i,
  input wire [2:0] three_closer_in_i,
  input wire [3:0] twohand_mixed_in_i,
  input wire [1:0] twohand_closer_in_i,
  input wire [1:0] selector_two_position_i,
  input wire [2:0] selector_three_position_i,
  output reg three_contact_static_and_o,
  output wire three_contact_timed_o,
  output reg three_closer_static_o,
  output wire three_closer_timed_o,
  output wire twohand_opener_pair_o,
  output wire twohand_closer_pair_o,
  output reg [1:0] selector_two_position_o,
  output reg [2:0] selector_three_position_o,
  output wire [3:0] fault_o
);

  // ==========================================================
  // Prescaler tick
  // One-cycle tick enable keeps every window on the single system clock
  // A prescale count that does not fit SSIE_PRE_W bits never produces a tick
  reg [`SSIE_PRE_W-1:0] pre_cnt;
  reg tick;
  // [R14] Fixed prescaler
  always @(posedge clk_i) begin
    if (srst_i) begin
      pre_cnt <= {`SSIE_PRE_W{1'b0}};
      tick <= 1'b0;
    end else if (pre_cnt == PRESCALE - 1) begin
      pre_cnt <= {`SSIE_PRE_W{1'b0}};
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ==========================================================
  // Start, complete and rest conditions per monitored group
  wire [3:0] timer_start_condition;
  wire [3:0] timer_complete_condition;
  wire [3:0] twohand_timer_condition;
  wire [3:0] group_rest;
  wire [3:0] discrepancy_timer_result;

  // [R1] Two-closer/one-opener conditions
  assign timer_start_condition[0] = three_contact_in_i[0] | three_contact_in_i[1] | ~three_contact_in_i[2];
  assign timer_complete_condition[0] = three_contact_in_i[0] & three_contact_in_i[1] & ~three_contact_in_i[2];
  // [R4] Three-opener conditions
  assign timer_start_condition[1] = |three_closer_in_i;
  assign timer_complete_condition[1] = &three_closer_in_i;
  // [R7] Start as OR over plain and inverted contacts
  // An opener rising or a closer falling leaves rest; the inverted terms are the closers
  wire [1:0] mixed_opener_left;
  wire [1:0] mixed_closer_left;
  assign mixed_opener_left = {twohand_mixed_in_i[2], twohand_mixed_in_i[0]};
  assign mixed_closer_left = {~twohand_mixed_in_i[3], ~twohand_mixed_in_i[1]};
  assign timer_start_condition[2] = (|mixed_opener_left) | (|mixed_closer_left);
  // [R6] Actuated: both openers active, both closers inactive
  assign timer_complete_condition[2] = twohand_mixed_in_i[0] & ~twohand_mixed_in_i[1] &
                                       twohand_mixed_in_i[2] & ~twohand_mixed_in_i[3];
  // [R8] Leaving rest means either closer left 1
  assign timer_start_condition[3] = ~(twohand_closer_in_i[0] & twohand_closer_in_i[1]);
  // [R9] Both closer inputs inactive
  assign timer_complete_condition[3] = ~twohand_closer_in_i[0] & ~twohand_closer_in_i[1];

  assign twohand_timer_condition = timer_start_condition;
  // Rest is the complement of the start term, so a group at rest never opens a window
  assign group_rest = ~timer_start_condition;

  // ==========================================================
  // Window monitors; channels below SSIE_NUM_DISC time both directions
  genvar g;
  generate
    for (g = 0; g < `SSIE_NUM_MON; g = g + 1) begin : g_mon
      reg [2:0] st;
      reg [2:0] next_st;
      reg [`SSIE_CNT_W-1:0] cnt;
      reg [`SSIE_CNT_W-1:0] next_cnt;
      wire [`SSIE_CNT_W-1:0] limit;
      wire timed_release;
      wire expired;
      assign limit = (g < `SSIE_NUM_DISC) ? DISC_TICKS : SYNC_TICKS;
      // Discrepancy groups time the release as well; two-hand groups lock until rest instead
      assign timed_release = (g < `SSIE_NUM_DISC);
      // The first tick after entry may be partial, so a window can be short by up to one tick
      assign expired = tick && (cnt >= limit - 1'b1);

      always @* begin
        next_st = st;
        case (st)
          `SSIE_ST_IDLE: begin
            if (timer_complete_condition[g])
              next_st = `SSIE_ST_ACT;
            else if (twohand_timer_condition[g])
              next_st = `SSIE_ST_WAIT;
          end
          // [R5] Window must close before expiry
          `SSIE_ST_WAIT: begin
            if (timer_complete_condition[g])
              next_st = `SSIE_ST_ACT;
            else if (group_rest[g])
              next_st = `SSIE_ST_IDLE;
            else if (expired)
              next_st = `SSIE_ST_FAULT;
          end
          // Timed groups re-run the window when complete is lost short of rest
          `SSIE_ST_ACT: begin
            if (timer_complete_condition[g])
              next_st = `SSIE_ST_ACT;
            else if (group_rest[g])
              next_st = `SSIE_ST_IDLE;
            else if (timed_release)
              next_st = `SSIE_ST_WAIT;
            else
              next_st = `SSIE_ST_LOCK;
          end
          // [R13] Fault held until rest
          `SSIE_ST_FAULT: begin
            if (group_rest[g])
              next_st = `SSIE_ST_IDLE;
          end
          // Two-hand release is untimed, but a re-press needs full rest first
          `SSIE_ST_LOCK: begin
            if (group_rest[g])
              next_st = `SSIE_ST_IDLE;
          end
          default: next_st = `SSIE_ST_IDLE;
        endcase
      end

      // Count restarts on every entry to the wait state, so a timed release gets a fresh window
      always @* begin
        next_cnt = cnt;
        if (next_st != `SSIE_ST_WAIT || st != `SSIE_ST_WAIT) begin
          next_cnt = {`SSIE_CNT_W{1'b0}};
        end else if (tick) begin
          next_cnt = cnt + 1'b1;
        end
      end

      always @(posedge clk_i) begin
        if (srst_i) begin
          st <= `SSIE_ST_IDLE;
          cnt <= {`SSIE_CNT_W{1'b0}};
        end else begin
          st <= next_st;
          cnt <= next_cnt;
        end
      end

      assign discrepancy_timer_result[g] = (st == `SSIE_ST_ACT);
      // Fault is a level that stands until the group is back at rest
      assign fault_o[g] = (st == `SSIE_ST_FAULT);
    end
  endgenerate

  // ==========================================================
  // Timed and two-hand outputs
  wire [1:0] twohand_monitor_result;
  assign twohand_monitor_result = discrepancy_timer_result[3:2];

  // [R1] Timed two-closer/one-opener output
  assign three_contact_timed_o = discrepancy_timer_result[0];
  // [R4] Timed three-opener output
  assign three_closer_timed_o = discrepancy_timer_result[1];
  // [R5] Two-hand mixed output
  assign twohand_opener_pair_o = twohand_monitor_result[0];
  // [R8] Two-hand closer pair output
  assign twohand_closer_pair_o = twohand_monitor_result[1];

  // ==========================================================
  // Static decodes, registered
  wire evaluated_output_bit;
  wire evaluated_output_second;
  wire evaluated_output_third;
  // [R11] First position alone
  assign evaluated_output_bit = selector_three_position_i[0] & ~selector_three_position_i[1] &
                                ~selector_three_position_i[2];
  // [R12] Single selection only
  assign evaluated_output_second = ~selector_three_position_i[0] & selector_three_position_i[1] &
                                   ~selector_three_position_i[2];
  assign evaluated_output_third = ~selector_three_position_i[0] & ~selector_three_position_i[1] &
                                  selector_three_position_i[2];

  wire next_static_and;
  wire next_closer_static;
  wire [1:0] next_sel_two;
  wire [2:0] next_sel_three;
  // [R2] Static two-closer/one-opener
  assign next_static_and = timer_complete_condition[0];
  // [R3] Static three-opener AND
  assign next_closer_static = timer_complete_condition[1];
  // [R10] Two-position exclusive decode
  assign next_sel_two = {~selector_two_position_i[0] & selector_two_position_i[1],
                         selector_two_position_i[0] & ~selector_two_position_i[1]};
  assign next_sel_three = {evaluated_output_third, evaluated_output_second, evaluated_output_bit};

  always @(posedge clk_i) begin
    if (srst_i) begin
      three_contact_static_and_o <= 1'b0;
      three_closer_static_o <= 1'b0;
      selector_two_position_o <= 2'h0;
      selector_three_position_o <= 3'h0;
    end else begin
      three_contact_static_and_o <= next_static_and;
      three_closer_static_o <= next_closer_static;
      selector_two_position_o <= next_sel_two;
      selector_three_position_o <= next_sel_three;
    end
  end

endmodule

/* File: ssie_switch_model.sv */
// Switch contact model driving the evaluator inputs
`timescale 1ns/100ps
module ssie_switch_model (
  input wire clk_i,
  input wire [16:0] want_i,
  output reg [16:0] pins_o
);
  // Contacts settle one cycle late, always at the falling edge
  initial pins_o = 17'h00000;
  always @(negedge clk_i) begin
    pins_o <= want_i;
  end
endmodule

/* File: ssie_top_sva.sv */
// Port checker for the switch input evaluator
`timescale 1ns/100ps
module ssie_top_sva (
  input wire clk_i,
  input wire srst_i,
  input wire [2:0] three_contact_in_i,
  input wire [2:0] three_closer_in_i,
  input wire [3:0] twohand_mixed_in_i,
  input wire [1:0] twohand_closer_in_i,
  input wire [1:0] selector_two_position_i,
  input wire [2:0] selector_three_position_i,
  input wire three_contact_static_and_o,
  input wire three_contact_timed_o,
  input wire three_closer_static_o,
  input wire three_closer_timed_o,
  input wire twohand_opener_pair_o,
  input wire twohand_closer_pair_o,
  input wire [1:0] selector_two_position_o,
  input wire [2:0] selector_three_position_o,
  input wire [3:0] fault_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_pair_fault_open;
    fault_o[3] && twohand_closer_in_i != 2'h3;
  endsequence
  sequence s_mixed_fault_rest;
    fault_o[2] && twohand_mixed_in_i == 4'hA;
  endsequence
  chk_contact_static: assert property (three_contact_static_and_o == $past(three_contact_in_i == 3'h3))
    else $error("contact static output wrong");
  chk_closer_static: assert property (three_closer_static_o == $past(&three_closer_in_i))
    else $error("closer static output wrong");
  chk_sel_two: assert property (selector_two_position_o ==
    $past({selector_two_position_i == 2'h2, selector_two_position_i == 2'h1}))
    else $error("two position decode wrong");
  chk_sel_three: assert property (selector_three_position_o ==
    $past({selector_three_position_i == 3'h4, selector_three_position_i == 3'h2,
    selector_three_position_i == 3'h1}))
    else $error("three position decode wrong");
  chk_contact_timed: assert property (three_contact_timed_o |-> $past(three_contact_in_i == 3'h3))
    else $error("timed contact high without complete");
  chk_closer_timed: assert property (three_closer_timed_o |-> $past(three_closer_in_i == 3'h7))
    else $error("timed closer high without complete");
  chk_mixed_act: assert property (twohand_opener_pair_o |-> $past(twohand_mixed_in_i == 4'h5))
    else $error("mixed two-hand high when not actuated");
  chk_pair_act: assert property (twohand_closer_pair_o |-> $past(twohand_closer_in_i == 2'h0))
    else $error("closer pair high when not actuated");
  chk_fault_masks: assert property ((fault_o & {twohand_closer_pair_o, twohand_opener_pair_o,
    three_closer_timed_o, three_contact_timed_o}) == 4'h0)
    else $error("output high while fault held");
  chk_fault_hold: assert property (s_pair_fault_open |=> fault_o[3])
    else $error("fault dropped before rest");
  chk_fault_clear: assert property (s_mixed_fault_rest |=> !fault_o[2])
    else $error("fault kept after rest");
  chk_mixed_fault_cause: assert property ($rose(fault_o[2]) |->
    $past(twohand_mixed_in_i != 4'h5 && twohand_mixed_in_i != 4'hA))
    else $error("mixed fault raised at rest or when actuated");
endmodule
bind ssie_top ssie_top_sva u_sva (.*);

/* File: ssie_top_tb_top.sv */
// Self-checking bench for the switch input evaluator
`timescale 1ns/100ps
module ssie_top_tb_top;
  localparam [16:0] REST = 17'h00E84;
  // Per channel complete and partial contact vectors, channel 0 lowest
  localparam [67:0] COMP = {17'h00284, 17'h00D44, 17'h00EBC, 17'h00E83};
  localparam [67:0] PART = {17'h00A84, 17'h00EC4, 17'h00E8C, 17'h00E85};
  reg clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg [16:0] want = 17'h00000;
  reg [31:0] rnd;
  wire [16:0] pins;
  wire [6:0] stat;
  wire [3:0] tim;
  wire [3:0] fault_o;
  integer fail_count = 0;
  integer checks_done = 0;
  integer i;
  integer k;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  ssie_switch_model u_sw (.clk_i(clk_i), .want_i(want), .pins_o(pins));
  ssie_top #(.PRESCALE(4), .DISC_TICKS(12'h003), .SYNC_TICKS(12'h002)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .three_contact_in_i(pins[2:0]), .three_closer_in_i(pins[5:3]), .twohand_mixed_in_i(pins[9:6]),
    .twohand_closer_in_i(pins[11:10]), .selector_two_position_i(pins[13:12]), .selector_three_position_i(pins[16:14]),
    .three_contact_static_and_o(stat[0]), .three_closer_static_o(stat[1]), .selector_two_position_o(stat[3:2]),
    .selector_three_position_o(stat[6:4]), .three_contact_timed_o(tim[0]), .three_closer_timed_o(tim[1]),
    .twohand_opener_pair_o(tim[2]), .twohand_closer_pair_o(tim[3]), .fault_o(fault_o));
  function [6:0] exp_static(input [16:0] p);
    exp_static = {p[16:14] == 3'h4, p[16:14] == 3'h2, p[16:14] == 3'h1, p[13:12] == 2'h2, p[13:12] == 2'h1,
      p[5:3] == 3'h7, p[2:0] == 3'h3};
  endfunction
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task drive(input [16:0] v, input integer n);
    begin
      want <= v;
      repeat (n) @(negedge clk_i);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count = fail_count + 1;
    finish_test;
  end
  // ==========================================
  // Main sequence
  initial begin
    rnd = $urandom(46199);
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    // First pass forces every selector position at once
    for (i = 0; i < 150; i = i + 1) begin
      rnd = (i == 0) ? 32'h0001F03F : $urandom;
      drive(rnd[16:0], 2);
      check({1'b0, stat}, {1'b0, exp_static(want)});
    end
    for (k = 0; k < 4; k = k + 1) begin
      drive(REST, 20);
      check({fault_o, tim}, 8'h00);
      drive(PART[17*k +: 17], 2);
      drive(COMP[17*k +: 17], 3);
      check({fault_o, tim}, 8'h01 << k);
      // Partial release then re-press: timed groups re-run the window, two-hand groups lock
      drive(PART[17*k +: 17], 2);
      drive(COMP[17*k +: 17], 3);
      check({fault_o, tim}, (k < 2) ? (8'h01 << k) : 8'h00);
      drive(REST, 3);
      check({fault_o, tim}, 8'h00);
      drive(PART[17*k +: 17], 20);
      check({fault_o, tim}, 8'h10 << k);
      drive(COMP[17*k +: 17], 4);
      check({fault_o, tim}, 8'h10 << k);
    end
    drive(REST, 3);
    check({fault_o, tim}, 8'h00);
    finish_test;
  end
endmodule
